// *** verilog/flash_query_table.sv ***
// Query table block with an Avalon-MM register slave
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "flash_query_defs.svh"
module flash_query_table (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest
);

  // Bus slave state
  flash_query_pkg::bus_state_type state_reg;
  flash_query_pkg::bus_state_type state_next;
  logic [31:0]                    readdata_reg;
  logic [31:0]                    readdata_next;

  // Software visible state
  flash_query_pkg::ctrl_type      ctrl_reg;
  flash_query_pkg::ctrl_type      ctrl_next;
  logic [8:0]                     qaddr_reg;
  logic [8:0]                     qaddr_next;
  logic [7:0]                     readCount_reg;
  logic [7:0]                     readCount_next;
  logic                           lastHit_reg;
  logic                           lastHit_next;

  // Lookup results, one lane per consecutive offset
  logic [31:0]                    wideWord;
  logic [3:0]                     laneHit;
  logic [15:0]                    queryWord;

  // Request decode
  logic                           request;
  logic                           accept;
  logic                           isData;
  logic                           isWide;

  // Geometry decoded from the region one descriptor, and the status and control words
  logic [15:0]                    blockCount;
  logic [15:0]                    blockUnits;
  logic [31:0]                    geomWord;
  logic [31:0]                    statusWord;
  logic [31:0]                    ctrlWord;

  // Request and acceptance of a bus cycle
  assign request = read | write;
  assign accept  = request && (state_reg == flash_query_pkg::ST_RESP);
  assign isData  = (address == `REG_QDATA);
  assign isWide  = (address == `REG_QWIDE);

  // Four lookup lanes at qaddr, qaddr+1, qaddr+2 and qaddr+3
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : gLane
      logic [8:0]                 laneAddr;
      flash_query_pkg::qbyte_type geoByte;
      flash_query_pkg::qbyte_type extByte;

      assign laneAddr = qaddr_reg + 9'(lane);

      geometry_rom uGeo (
        .qAddr   (laneAddr),
        .density (ctrl_reg.density),
        .qByte   (geoByte)
      );

      ext_query_rom uExt (
        .qAddr  (laneAddr),
        .muxBus (ctrl_reg.muxBus),
        .qByte  (extByte)
      );

      // The two tables never overlap, so an OR merges them
      assign wideWord[lane*8 +: 8] = geoByte.value | extByte.value;
      assign laneHit[lane]         = geoByte.hit | extByte.hit;
    end
  endgenerate

  // Byte on the low lane, upper byte held at zero while querying
  assign queryWord = ctrl_reg.queryEn ? {8'h00, wideWord[7:0]} : 16'h0000;

  // Region one descriptor split into count and size fields
  assign blockCount = wideWord[15:0] + 16'h0001;
  assign blockUnits = wideWord[31:16];

  // Decoded geometry read by software, only at the region one descriptor
  always_comb begin
    geomWord = 32'h0000_0000;
    if (qaddr_reg == `Q_R1_Y_LO) begin
      geomWord = {blockUnits, blockCount};
    end
  end

  // Status word
  always_comb begin
    statusWord         = 32'h0000_0000;
    statusWord[0]      = ctrl_reg.queryEn;
    statusWord[1]      = lastHit_reg;
    statusWord[2]      = laneHit[0];
    statusWord[15:8]   = readCount_reg;
    statusWord[24:16]  = qaddr_reg;
  end

  // Control word as read back
  always_comb begin
    ctrlWord      = 32'h0000_0000;
    ctrlWord[4:0] = ctrl_reg;
  end

  // Bus state machine: one wait cycle, then the answer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      flash_query_pkg::ST_IDLE: begin
        if (request) begin
          state_next = flash_query_pkg::ST_RESP;
        end
      end
      flash_query_pkg::ST_RESP: begin
        state_next = flash_query_pkg::ST_IDLE;
      end
      default: begin
        state_next = flash_query_pkg::ST_IDLE;
      end
    endcase
  end

  // Wait until the answer cycle
  assign waitrequest = request && (state_reg != flash_query_pkg::ST_RESP);

  // Read data loaded in the wait cycle, held until the next read
  always_comb begin
    readdata_next = readdata_reg;
    if (read && (state_reg == flash_query_pkg::ST_IDLE)) begin
      case (address)
        `REG_CTRL:   readdata_next = ctrlWord;
        `REG_QADDR:  readdata_next = {23'h000000, qaddr_reg};
        `REG_QDATA:  readdata_next = {16'h0000, queryWord};
        `REG_QWIDE:  readdata_next = ctrl_reg.queryEn ? wideWord : 32'h0000_0000;
        `REG_STATUS: readdata_next = statusWord;
        `REG_GEOM:   readdata_next = geomWord;
        default:     readdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Control register writes honour the low byte lane
  always_comb begin
    ctrl_next = ctrl_reg;
    if (accept && write && (address == `REG_CTRL) && byteenable[0]) begin
      ctrl_next = flash_query_pkg::ctrl_type'(writedata[4:0]);
    end
  end

  // Query address: written, or stepped after a data read
  always_comb begin
    qaddr_next = qaddr_reg;
    if (accept && write && (address == `REG_QADDR)) begin
      if (byteenable[0]) begin
        qaddr_next[7:0] = writedata[7:0];
      end
      if (byteenable[1]) begin
        qaddr_next[8] = writedata[8];
      end
    end else if (accept && read && ctrl_reg.autoInc && ctrl_reg.queryEn) begin
      if (isData) begin
        qaddr_next = qaddr_reg + 9'h001;
      end else if (isWide) begin
        qaddr_next = qaddr_reg + 9'h004;
      end
    end
  end

  // Count query reads and remember whether the last one hit the table
  always_comb begin
    readCount_next = readCount_reg;
    lastHit_next   = lastHit_reg;
    if (accept && read && (isData || isWide)) begin
      readCount_next = readCount_reg + 8'h01;
      lastHit_next   = laneHit[0];
    end
  end

  // Bus state register
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= flash_query_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (srst) begin
      readdata_reg <= 32'h0000_0000;
    end else begin
      readdata_reg <= readdata_next;
    end
  end

  // Control register
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_reg <= flash_query_pkg::ctrl_type'(`CTRL_RESET);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Query address register
  always_ff @(posedge clock) begin
    if (srst) begin
      qaddr_reg <= `QADDR_RESET;
    end else begin
      qaddr_reg <= qaddr_next;
    end
  end

  // Query read counter and last hit flag
  always_ff @(posedge clock) begin
    if (srst) begin
      readCount_reg <= 8'h00;
      lastHit_reg   <= 1'b0;
    end else begin
      readCount_reg <= readCount_next;
      lastHit_reg   <= lastHit_next;
    end
  end

  // Read data straight from its register
  assign readdata = readdata_reg;

endmodule

// *** pkg/flash_query_defs.svh ***
// Constants for the flash query geometry and extended query table
// Operation
// - Offset 27h returns log2 of device byte size
// - Interface code bytes 28h/29h read 01, 00
// - Write buffer exponent at 2Ah/2Bh reads 0A, 00
// - Offset 2Ch reports one erase block region
// - Region descriptor: y+1 blocks, z*256 byte size
// - Region one bytes depend on selected density
// - Second region descriptor sits at 31h-34h
// - Offsets 35h-38h reserved, no region data
// - Extended table starts with signature 50,52,49
// - Version digits at base+3, base+4: 31, 34
// - Feature bytes E6/66 by bus, 07, 00, 00
// - Feature bits 11 to 31 read zero
// - Feature bit 0 zero, no chip erase
// - Pointer at 15h/16h gives base 010Ah
`ifndef FLASH_QUERY_DEFS_SVH
`define FLASH_QUERY_DEFS_SVH
`define REG_CTRL        5'h00
`define REG_QADDR       5'h04
`define REG_QDATA       5'h08
`define REG_QWIDE       5'h0C
`define REG_STATUS      5'h10
`define REG_GEOM        5'h14
`define CTRL_MUX_BIT    2
`define CTRL_QEN_BIT    3
`define CTRL_AINC_BIT   4
`define CTRL_RESET      5'h08
`define QADDR_RESET     9'h000
`define Q_PTR_LO        9'h015
`define Q_PTR_HI        9'h016
`define Q_SIZE          9'h027
`define Q_IFACE_LO      9'h028
`define Q_IFACE_HI      9'h029
`define Q_WBUF_LO       9'h02A
`define Q_WBUF_HI       9'h02B
`define Q_REGIONS       9'h02C
`define Q_R1_Y_LO       9'h02D
`define Q_R1_Y_HI       9'h02E
`define Q_R1_Z_LO       9'h02F
`define Q_R1_Z_HI       9'h030
`define Q_R2_FIRST      9'h031
`define Q_R2_LAST       9'h034
`define Q_RSV_FIRST     9'h035
`define Q_RSV_LAST      9'h038
`define Q_EXT_BASE      9'h10A
`define Q_EXT_LAST      9'h112
`define CODE_SIZE_128   8'h18
`define CODE_SIZE_256   8'h19
`define CODE_SIZE_512   8'h1A
`define CODE_SIZE_1G    8'h1B
`define CODE_IFACE      8'h01
`define CODE_WBUF       8'h0A
`define CODE_REGIONS    8'h01
`define CODE_Y_LO_FULL  8'hFF
`define CODE_Y_LO_256   8'h7F
`define CODE_Y_HI_1G    8'h01
`define CODE_Z_HI       8'h04
`define CODE_EMPTY      8'h00
`define CODE_PTR_LO     8'h0A
`define CODE_PTR_HI     8'h01
`define CODE_SIG0       8'h50
`define CODE_SIG1       8'h52
`define CODE_SIG2       8'h49
`define CODE_VER_MAJ    8'h31
`define CODE_VER_MIN    8'h34
`define CODE_FEAT_NOMUX 8'hE6
`define CODE_FEAT_MUX   8'h66
`define CODE_FEAT1      8'h07
`endif

// *** pkg/flash_query_pkg.sv ***
// Types shared by the flash query table modules
package flash_query_pkg;

  // Density selection of the emulated part
  typedef enum logic [1:0] {
    DENS_128M = 2'h0,
    DENS_256M = 2'h1,
    DENS_512M = 2'h2,
    DENS_1G   = 2'h3
  } density_type;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } bus_state_type;

  // Control register fields
  typedef struct packed {
    logic        autoInc;
    logic        queryEn;
    logic        muxBus;
    density_type density;
  } ctrl_type;

  // One looked-up table byte with its hit flag
  typedef struct packed {
    logic       hit;
    logic [7:0] value;
  } qbyte_type;

endpackage

// *** verilog/geometry_rom.sv ***
// Device geometry bytes, offsets 27h to 38h
`timescale 1ns/1ps
`include "flash_query_defs.svh"
module geometry_rom (
  // Lookup
  input  wire logic [8:0]                qAddr,
  input  wire flash_query_pkg::density_type density,
  // Result
  output flash_query_pkg::qbyte_type     qByte
);

  // Table decode; every byte not listed reads as zero
  always_comb begin
    qByte.hit   = 1'b1;
    qByte.value = `CODE_EMPTY;
    case (qAddr)
      `Q_SIZE: begin
        case (density)
          flash_query_pkg::DENS_128M: qByte.value = `CODE_SIZE_128;
          flash_query_pkg::DENS_256M: qByte.value = `CODE_SIZE_256;
          flash_query_pkg::DENS_512M: qByte.value = `CODE_SIZE_512;
          default:                    qByte.value = `CODE_SIZE_1G;
        endcase
      end
      `Q_IFACE_LO: qByte.value = `CODE_IFACE;
      `Q_IFACE_HI: qByte.value = `CODE_EMPTY;
      `Q_WBUF_LO:  qByte.value = `CODE_WBUF;
      `Q_WBUF_HI:  qByte.value = `CODE_EMPTY;
      `Q_REGIONS:  qByte.value = `CODE_REGIONS;
      `Q_R1_Y_LO:  qByte.value = (density == flash_query_pkg::DENS_256M) ? `CODE_Y_LO_256 : `CODE_Y_LO_FULL;
      `Q_R1_Y_HI:  qByte.value = (density == flash_query_pkg::DENS_1G) ? `CODE_Y_HI_1G : `CODE_EMPTY;
      `Q_R1_Z_LO:  qByte.value = `CODE_EMPTY;
      `Q_R1_Z_HI:  qByte.value = `CODE_Z_HI;
      default: begin
        // Second region has no blocks, reserved span carries nothing
        qByte.hit = ((qAddr >= `Q_R2_FIRST) && (qAddr <= `Q_R2_LAST))
                 || ((qAddr >= `Q_RSV_FIRST) && (qAddr <= `Q_RSV_LAST));
      end
    endcase
  end

endmodule

// *** verilog/ext_query_rom.sv ***
// Extended query pointer and table bytes
`timescale 1ns/1ps
`include "flash_query_defs.svh"
module ext_query_rom (
  // Lookup
  input  wire logic [8:0]            qAddr,
  input  wire logic                  muxBus,
  // Result
  output flash_query_pkg::qbyte_type qByte
);

  logic [8:0] rel;

  // Offset inside the extended table
  assign rel = qAddr - `Q_EXT_BASE;

  // Table decode; higher feature bytes read zero
  always_comb begin
    qByte.hit   = 1'b1;
    qByte.value = `CODE_EMPTY;
    if (qAddr == `Q_PTR_LO) begin
      qByte.value = `CODE_PTR_LO;
    end else if (qAddr == `Q_PTR_HI) begin
      qByte.value = `CODE_PTR_HI;
    end else if ((qAddr >= `Q_EXT_BASE) && (qAddr <= `Q_EXT_LAST)) begin
      case (rel)
        9'h000:  qByte.value = `CODE_SIG0;
        9'h001:  qByte.value = `CODE_SIG1;
        9'h002:  qByte.value = `CODE_SIG2;
        9'h003:  qByte.value = `CODE_VER_MAJ;
        9'h004:  qByte.value = `CODE_VER_MIN;
        9'h005:  qByte.value = muxBus ? `CODE_FEAT_MUX : `CODE_FEAT_NOMUX;
        9'h006:  qByte.value = `CODE_FEAT1;
        default: qByte.value = `CODE_EMPTY;
      endcase
    end else begin
      qByte.hit = 1'b0;
    end
  end

endmodule

// *** sim/flash_query_table_asserts.sv ***
// Checker for the query table bus slave
`timescale 1ns/1ps
module flash_query_table_asserts (
  // Clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // Bus
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  // Load of the query address, then a wide read answered three edges on
  sequence setAddr(a);
    write && !waitrequest && address == 5'h04 && byteenable == 4'hF && writedata[8:0] == a;
  endsequence
  sequence wideDone;
    read && !waitrequest && address == 5'h0C;
  endsequence
  property wideValue(a, v);
    setAddr(a) ##3 wideDone |-> readdata == v;
  endproperty
  // Handshake timing and returned values
  wait_first_a: assert property ((read || write) && !$past(read || write) |-> waitrequest)
    else $error("new request answered without a wait cycle");
  one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("more than one wait cycle");
  idle_free_a: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high with no request");
  lane_upper_a: assert property (read && !waitrequest && address == 5'h08 |-> readdata[31:8] == 24'h0)
    else $error("upper lanes of byte read not zero");
  unmapped_zero_a: assert property (read && !waitrequest && address > 5'h14 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  ptr_value_a: assert property (wideValue(9'h015, 32'h0000010A))
    else $error("table pointer wrong");
  signature_a: assert property (wideValue(9'h10A, 32'h31495250))
    else $error("signature or version wrong");
  iface_wbuf_a: assert property (wideValue(9'h028, 32'h000A0001))
    else $error("interface or buffer code wrong");
  reserved_zero_a: assert property (wideValue(9'h035, 32'h0))
    else $error("reserved bytes not zero");
endmodule
bind flash_query_table flash_query_table_asserts u_chk (.clock, .srst, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest);

// *** sim/query_host.sv ***
// Host model issuing register and query reads over the bus
`timescale 1ns/1ps
module query_host (
  // Clock
  input wire logic        clock,
  // Bus
  output logic [4:0]      address,
  output logic            read,
  output logic            write,
  output logic [31:0]     writedata,
  output logic [3:0]      byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest
);
  // Idle bus at time zero
  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hF;
  end
  // One transfer, held until waitrequest is seen low
  task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] wd, input int gap,
                        output logic [31:0] rd);
    repeat (gap + 1) @(posedge clock);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= wd;
    // Held until the rising edge that samples waitrequest low
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~wd; // Released data no longer shows the last value
  endtask
endmodule

// *** sim/flash_query_table_bench.sv ***
// Self-checking bench for the flash query table
`timescale 1ns/1ps
module flash_query_table_bench;
  logic        clock;
  logic        srst;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [31:0] rd;
  logic [2:0]  dm;
  logic [8:0]  qa;
  logic [8:0]  offs [9] = '{9'h015, 9'h027, 9'h028, 9'h02C, 9'h030, 9'h035, 9'h10A, 9'h10E, 9'h111};
  int          failures;
  int          num_checks;
  int          seed;
  logic        slow;

  flash_query_table u_dut (.clock, .srst, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest);
  query_host u_host (.clock, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest);

  // Clock at 100 ns
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Expected table byte for density, bus variant and offset
  function automatic logic [7:0] exp_byte(input logic [1:0] d, input logic m, input logic [8:0] a);
    case (a)
      9'h015: return 8'h0A;
      9'h016: return 8'h01;
      9'h027: return 8'h18 + {6'h0, d};
      9'h028: return 8'h01;
      9'h02A: return 8'h0A;
      9'h02C: return 8'h01;
      9'h02D: return (d == 2'h1) ? 8'h7F : 8'hFF;
      9'h02E: return (d == 2'h3) ? 8'h01 : 8'h00;
      9'h030: return 8'h04;
      9'h10A: return 8'h50;
      9'h10B: return 8'h52;
      9'h10C: return 8'h49;
      9'h10D: return 8'h31;
      9'h10E: return 8'h34;
      9'h10F: return m ? 8'h66 : 8'hE6;
      9'h110: return 8'h07;
      default: return 8'h00;
    endcase
  endfunction
  // Four bytes, lowest offset in the low lane
  function automatic logic [31:0] wide(input logic [1:0] d, input logic m, input logic [8:0] a);
    return {exp_byte(d, m, a + 9'h3), exp_byte(d, m, a + 9'h2), exp_byte(d, m, a + 9'h1), exp_byte(d, m, a)};
  endfunction

  // Compare one read value
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  // Bus write and checked read
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    u_host.access(1'b1, a, d, slow ? {$random(seed)} % 3 : 0, rd);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    u_host.access(1'b0, a, 32'h0, slow ? {$random(seed)} % 3 : 0, rd);
    check(rd, e);
  endtask
  // Counts and verdict
  task automatic close_out;
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #1000000;
    failures++;
    close_out;
  end

  // Main sequence
  initial begin
    seed = 13;
    failures = 0;
    num_checks = 0;
    slow = 1'b0;
    srst = 1'b1;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    rdc(5'h00, 32'h00000008);
    $display("test reset done");
    wr(5'h00, 32'h0000001B);
    wr(5'h04, 32'h0000002D);
    rdc(5'h04, 32'h0000002D);
    rdc(5'h14, 32'h04000200);
    rdc(5'h0C, wide(2'h3, 1'b0, 9'h02D));
    rdc(5'h04, 32'h00000031);
    rdc(5'h08, 32'h00000000);
    rdc(5'h10, 32'h00320207);
    // Second reset in mid-run
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rdc(5'h10, 32'h00000001);
    rdc(5'h00, 32'h00000008);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      dm = 3'(k);
      wr(5'h00, {28'h0, 1'b1, dm});
      foreach (offs[i]) begin
        wr(5'h04, {23'h0, offs[i]});
        rdc(5'h0C, wide(dm[1:0], dm[2], offs[i]));
      end
    end
    $display("test wide table done");
    wr(5'h00, 32'h00000018);
    wr(5'h04, 32'h0000010A);
    for (int i = 0; i < 9; i++)
      rdc(5'h08, {24'h0, exp_byte(2'h0, 1'b0, 9'h10A + 9'(i))});
    $display("test extended walk done");
    slow = 1'b1;
    repeat (40) begin
      dm = 3'($random(seed));
      qa = 9'($random(seed));
      wr(5'h00, {28'h0, 1'b1, dm});
      wr(5'h04, {23'h0, qa});
      rdc(5'h08, {24'h0, exp_byte(dm[1:0], dm[2], qa)});
    end
    $display("test random done");
    wr(5'h00, 32'h00000000);
    wr(5'h04, 32'h00000027);
    rdc(5'h08, 32'h0);
    wr(5'h18, 32'hFFFFFFFF);
    rdc(5'h18, 32'h0);
    rdc(5'h00, 32'h0);
    $display("test refusals done");
    close_out;
  end
endmodule
